// file: port_speed_mode_straps_bench.sv
// self-checking bench of the strap loader
`include "psm_defs.svh"
module port_speed_mode_straps_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import psm_pkg::*;
    logic clk_in = 0, rst_in = 1, wr = 0, rd = 0;
    logic [3:0] addr = 4'h0, lo, hi, fit = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [7:0] code = 8'h00;
    logic rate = 1, rfit = 0, side = 1, rpin, spin, r100, seg, phy, vld;
    psm_port_cfg_t [3:0] cfg;
    psm_pin_t txc, rxc;
    int errors = 0, comparisons = 0, n;
    psm_board_model psm_board_model_inst (.code_in(code),
        .fitted_in(fit), .rate_in(rate), .rate_fitted_in(rfit),
        .side_in(side), .low_out(lo), .high_out(hi), .rate_out(rpin),
        .side_out(spin));
    psm_strap_loader psm_strap_loader_inst (.clk_in(clk_in),
        .rst_in(rst_in), .line_port_speed_code_low_in(lo),
        .line_port_speed_code_high_in(hi),
        .expansion_port_rate_select_in(rpin),
        .expansion_port_side_select_in(spin), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .port_cfg_out(cfg), .rate_100_out(r100),
        .stats_segment_100_out(seg), .phy_side_out(phy),
        .config_valid_out(vld), .expansion_tx_clock_out(txc),
        .expansion_rx_clock_out(rxc));
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic close_out();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge clk_in) rst_in <= 1'h1;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'h0;
        n = 0;
        while (vld !== 1'h1 && n < 10) begin
            @(negedge clk_in);
            n++;
        end
        chk("valid", 1, vld);
    endtask
    task automatic wr_reg(logic [3:0] a, logic [31:0] d);
        @(posedge clk_in) begin
            addr <= a; wdata <= d; wr <= 1'h1;
        end
        @(posedge clk_in) wr <= 1'h0;
    endtask
    task automatic rd_reg(logic [3:0] a, logic [31:0] e);
        @(posedge clk_in) begin
            addr <= a; rd <= 1'h1;
        end
        @(posedge clk_in) rd <= 1'h0;
        @(negedge clk_in) chk("rdata", e, rdata);
        @(negedge clk_in) chk("rdata idle", 0, rdata);
    endtask
    task automatic chk_cfg(logic [7:0] c);
        for (int i = 0; i < 4; i++)
            chk("cfg", 4'h8 >> c[2*i+:2], 32'(cfg[i]));
    endtask
    task automatic t_defaults();
        @(negedge clk_in);
        chk("rst cfg", 16'h1111, 32'(cfg));
        chk("rst oe", 0, {txc.oe, rxc.oe, vld, rdata[0]});
        do_reset();
        chk_cfg(8'hFF);
        rd_reg(`PSM_REG_STATUS, 32'h7FF);
    endtask
    task automatic t_codes();
        @(posedge clk_in);
        fit <= 4'hF;
        code <= 8'hE4;
        do_reset();
        chk_cfg(8'hE4);
        rd_reg(`PSM_REG_STATUS, 32'h7E4);
        rd_reg(`PSM_REG_PINS, 32'h3CA);
        rd_reg(4'hC, 0);
        wr_reg(`PSM_REG_STATUS, 32'h0);
        rd_reg(`PSM_REG_STATUS, 32'h7E4);
        wr_reg(`PSM_REG_OVERRIDE, 32'h11);
        @(negedge clk_in) chk("ovr", 4'h4, 32'(cfg[0]));
        rd_reg(`PSM_REG_OVERRIDE, 32'h11);
        wr_reg(`PSM_REG_OVERRIDE, 32'h0);
        @(negedge clk_in) chk_cfg(8'hE4);
    endtask
    task automatic t_side();
        @(posedge clk_in);
        side <= 1'h0;
        code <= 8'h1B;
        repeat (6) @(negedge clk_in);
        chk("side held", 1, phy);
        chk_cfg(8'hE4);
        do_reset();
        chk("mac side", 0, {phy, txc.oe, rxc.oe});
        chk_cfg(8'h1B);
        @(posedge clk_in) side <= 1'h1;
        do_reset();
        chk("phy side", 3'h7, {phy, txc.oe, rxc.oe});
    endtask
    task automatic t_rate();
        @(posedge clk_in);
        rfit <= 1'h1;
        rate <= 1'h0;
        repeat (4) @(negedge clk_in);
        chk("rate 10", 0, {r100, seg});
        n = 0;
        for (int i = 0; i < 20; i++) begin
            @(negedge clk_in) n += txc.o + rxc.o;
        end
        chk("slow clk", 20, n);
        @(posedge clk_in) rate <= 1'h1;
        repeat (4) @(negedge clk_in);
        chk("rate 100", 3, {r100, seg});
        @(posedge clk_in) #1 chk("fast clk", 3, {txc.o, rxc.o});
        @(negedge clk_in) chk("fast low", 0, {txc.o, rxc.o});
    endtask
    initial begin
        #200000;
        errors++;
        close_out();
    end
    initial begin
        t_defaults();
        t_codes();
        t_side();
        t_rate();
        close_out();
    end
endmodule

// file: psm_board_model.sv
// board straps with pull-ups and an attached controller's rate request
module psm_board_model (
    input  wire logic [7:0] code_in,
    input  wire logic [3:0] fitted_in,
    input  wire logic       rate_in,
    input  wire logic       rate_fitted_in,
    input  wire logic       side_in,
    output logic      [3:0] low_out,
    output logic      [3:0] high_out,
    output logic            rate_out,
    output logic            side_out
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            low_out[i] = fitted_in[i] ? code_in[2*i] : 1'h1;
            high_out[i] = fitted_in[i] ? code_in[2*i+1] : 1'h1;
        end
    end
    // slow rate only in phy side
    assign rate_out = rate_fitted_in ? (rate_in | ~side_in) : 1'h1;
    assign side_out = side_in;
endmodule

// file: psm_defs.svh
// constants of the port speed and mode strap loader
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH
`define PSM_NPORTS          4
`define PSM_ADDR_W          4
`define PSM_DATA_W          32
`define PSM_PIN_W           10
`define PSM_REG_STATUS      4'h0
`define PSM_REG_OVERRIDE    4'h4
`define PSM_REG_PINS        4'h8
`define PSM_STAT_PHY_BIT    8
`define PSM_STAT_RATE_BIT   9
`define PSM_STAT_VALID_BIT  10
`define PSM_OVR_CODE_LSB    4
`define PSM_PIN_RATE_BIT    8
`define PSM_PIN_SIDE_BIT    9
`define PSM_CODE_AUTONEG    2'h0
`define PSM_CODE_10T        2'h1
`define PSM_CODE_FX         2'h2
`define PSM_CODE_TX         2'h3
`define PSM_CODE_RST        2'h3
`define PSM_PHY_SIDE_RST    1'h1
`define PSM_RATE_RST        1'h1
`define PSM_OVR_EN_RST      4'h0
`define PSM_OVR_CODE_RST    8'hFF
`define PSM_SETTLE_CYCLES   2'h2
`define PSM_CLK_KHZ         25000
`define PSM_SLOW_CLK_KHZ    2500
`define PSM_SLOW_HALF_CYC   (`PSM_CLK_KHZ / (2 * `PSM_SLOW_CLK_KHZ))
`define PSM_DIV_W           3
`endif

// file: psm_pkg.sv
// types of the port speed and mode strap loader
package psm_pkg;
    typedef struct packed {
        logic autoneg;
        logic force_10t;
        logic force_fx;
        logic force_tx;
    } psm_port_cfg_t;

    typedef struct packed {
        logic o;
        logic oe;
    } psm_pin_t;

    typedef enum logic {
        PSM_SETTLE,
        PSM_RUN
    } psm_state_t;
endpackage

// file: psm_strap_loader.sv
// strap loader: per-port speed codes, expansion port rate and side
//
// Function
// R1: latch two-bit speed code per port at reset
// R2: rate input sets interface rate and statistics segment
// R3: host asks 10 Mbps only in PHY side
// R4: select high: act as PHY side, drive clocks
// R5: select low: act as MAC side, release clocks
// R6: side select captured only at reset
// R7: PHY side drives 2.5 or 25 MHz clock
// R8: floating inputs read high, giving 100BASE-TX
`include "psm_defs.svh"

module psm_strap_loader
    import psm_pkg::*;
(
    input  wire logic                          clk_in,
    input  wire logic                          rst_in,
    input  wire logic [`PSM_NPORTS-1:0]        line_port_speed_code_low_in,
    input  wire logic [`PSM_NPORTS-1:0]        line_port_speed_code_high_in,
    input  wire logic                          expansion_port_rate_select_in,
    input  wire logic                          expansion_port_side_select_in,
    input  wire logic [`PSM_ADDR_W-1:0]        reg_addr_in,
    input  wire logic [`PSM_DATA_W-1:0]        reg_wdata_in,
    input  wire logic                          reg_wr_in,
    input  wire logic                          reg_rd_in,
    output logic      [`PSM_DATA_W-1:0]        reg_rdata_out,
    output psm_port_cfg_t [`PSM_NPORTS-1:0]    port_cfg_out,
    output logic                               rate_100_out,
    output logic                               stats_segment_100_out,
    output logic                               phy_side_out,
    output logic                               config_valid_out,
    output psm_pin_t                           expansion_tx_clock_out,
    output psm_pin_t                           expansion_rx_clock_out
);

    logic [`PSM_PIN_W-1:0]         pin_sync1_r;
    logic [`PSM_PIN_W-1:0]         pin_sync2_r;
    psm_state_t                    state_r;
    logic [1:0]                    settle_cnt_r;
    logic [`PSM_NPORTS-1:0][1:0]   code_r;
    logic [`PSM_NPORTS-1:0][1:0]   eff_code;
    logic [`PSM_NPORTS-1:0]        ovr_en_r;
    logic [`PSM_NPORTS-1:0][1:0]   ovr_code_r;
    logic                          phy_side_r;
    logic                          rate_r;
    logic                          valid_r;
    logic [`PSM_DIV_W-1:0]         div_cnt_r;
    logic                          div_r;
    logic [`PSM_DATA_W-1:0]        rdata_r;
    logic [`PSM_DATA_W-1:0]        rdata_nxt;
    logic                          settle_done;
    logic                          drive_clk;
    logic                          tx_clk_src;

    localparam logic [`PSM_DIV_W-1:0] DIV_LAST =
        `PSM_DIV_W'(`PSM_SLOW_HALF_CYC - 1);

    // pins are board levels, foreign to clk_in; two flops before use
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_sync1_r <= '1;
            pin_sync2_r <= '1;
        end else begin
            pin_sync1_r <= {expansion_port_side_select_in,
                            expansion_port_rate_select_in,
                            line_port_speed_code_high_in,
                            line_port_speed_code_low_in};
            pin_sync2_r <= pin_sync1_r;
        end
    end

    // wait until the synchroniser holds post-reset pin levels
    assign settle_done = (settle_cnt_r == `PSM_SETTLE_CYCLES);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r      <= PSM_SETTLE;
            settle_cnt_r <= 2'h0;
        end else begin
            case (state_r)
                PSM_SETTLE: begin
                    if (settle_done) begin
                        state_r <= PSM_RUN;
                    end else begin
                        settle_cnt_r <= settle_cnt_r + 2'h1;
                    end
                end
                PSM_RUN: begin
                    state_r <= PSM_RUN;
                end
                default: begin
                    state_r <= PSM_SETTLE;
                end
            endcase
        end
    end

    // R1 capture speed codes
    // R6 side select caught once
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            code_r     <= {`PSM_NPORTS{`PSM_CODE_RST}};
            phy_side_r <= `PSM_PHY_SIDE_RST;
            valid_r    <= 1'h0;
        end else if (state_r == PSM_SETTLE && settle_done) begin
            for (int i = 0; i < `PSM_NPORTS; i++) begin
                code_r[i] <= {pin_sync2_r[i + `PSM_NPORTS],
                              pin_sync2_r[i]};
            end
            phy_side_r <= pin_sync2_r[`PSM_PIN_SIDE_BIT];
            valid_r    <= 1'h1;
        end
    end

    // R2 rate follows its input
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rate_r <= `PSM_RATE_RST;
        end else begin
            rate_r <= pin_sync2_r[`PSM_PIN_RATE_BIT];
        end
    end

    // software override lets a port be forced without rewiring straps
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ovr_en_r   <= `PSM_OVR_EN_RST;
            ovr_code_r <= `PSM_OVR_CODE_RST;
        end else if (reg_wr_in && reg_addr_in == `PSM_REG_OVERRIDE) begin
            ovr_en_r   <= reg_wdata_in[`PSM_NPORTS-1:0];
            ovr_code_r <= reg_wdata_in[`PSM_OVR_CODE_LSB +:
                                       2 * `PSM_NPORTS];
        end
    end

    genvar g;
    generate
        for (g = 0; g < `PSM_NPORTS; g++) begin : g_port
            assign eff_code[g] = ovr_en_r[g] ? ovr_code_r[g] : code_r[g];
            // R1 decode speed code
            // R8 code 11 is 100BASE-TX
            assign port_cfg_out[g].autoneg   =
                (eff_code[g] == `PSM_CODE_AUTONEG);
            assign port_cfg_out[g].force_10t =
                (eff_code[g] == `PSM_CODE_10T);
            assign port_cfg_out[g].force_fx  =
                (eff_code[g] == `PSM_CODE_FX);
            assign port_cfg_out[g].force_tx  =
                (eff_code[g] == `PSM_CODE_TX);
        end
    endgenerate

    // free-running divide for the 2.5 MHz clock
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_cnt_r <= '0;
            div_r     <= 1'h0;
        end else if (div_cnt_r == DIV_LAST) begin
            div_cnt_r <= '0;
            div_r     <= ~div_r;
        end else begin
            div_cnt_r <= div_cnt_r + `PSM_DIV_W'(1);
        end
    end

    // R7 clock source by rate
    // a rate change mid-run can give one short clock phase; the rate
    // strap is expected to be static while traffic flows
    assign tx_clk_src = rate_r ? clk_in : div_r;

    // R4 PHY side drives clocks
    // R5 MAC side leaves clocks to the PHY
    assign drive_clk = valid_r & phy_side_r;

    assign expansion_tx_clock_out.o  = drive_clk & tx_clk_src;
    assign expansion_tx_clock_out.oe = drive_clk;
    assign expansion_rx_clock_out.o  = drive_clk & tx_clk_src;
    assign expansion_rx_clock_out.oe = drive_clk;

    // R2 rate and statistics segment
    assign rate_100_out          = rate_r;
    assign stats_segment_100_out = rate_r;
    assign phy_side_out          = phy_side_r;
    assign config_valid_out      = valid_r;

    always_comb begin
        rdata_nxt = '0;
        case (reg_addr_in)
            `PSM_REG_STATUS: begin
                for (int i = 0; i < `PSM_NPORTS; i++) begin
                    rdata_nxt[2 * i +: 2] = code_r[i];
                end
                rdata_nxt[`PSM_STAT_PHY_BIT]   = phy_side_r;
                rdata_nxt[`PSM_STAT_RATE_BIT]  = rate_r;
                rdata_nxt[`PSM_STAT_VALID_BIT] = valid_r;
            end
            `PSM_REG_OVERRIDE: begin
                rdata_nxt[`PSM_NPORTS-1:0] = ovr_en_r;
                rdata_nxt[`PSM_OVR_CODE_LSB +: 2 * `PSM_NPORTS] =
                    ovr_code_r;
            end
            `PSM_REG_PINS: begin
                rdata_nxt[`PSM_PIN_W-1:0] = pin_sync2_r;
            end
            default: begin
                rdata_nxt = '0;
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_r <= '0;
        end else if (reg_rd_in) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= '0;
        end
    end

    assign reg_rdata_out = rdata_r;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    generate
        for (g = 0; g < `PSM_NPORTS; g++) begin : g_chk
            property p_port_code;
                state_r == PSM_RUN && !ovr_en_r[g] |->
                    eff_code[g] == code_r[g] &&
                    $onehot(port_cfg_out[g]);
            endproperty
            a_port_code: assert property (p_port_code) // R1
                else $error("port mode does not follow latched code");
        end
    endgenerate

    property p_latch_once;
        state_r == PSM_RUN && $past(state_r) == PSM_RUN |->
            $stable(code_r) && $stable(phy_side_r) && valid_r;
    endproperty
    a_latch_once: assert property (p_latch_once) // R6
        else $error("strap capture changed after reset");

    property p_capture;
        state_r == PSM_SETTLE && settle_done |=>
            config_valid_out &&
            phy_side_out == $past(pin_sync2_r[`PSM_PIN_SIDE_BIT]);
    endproperty
    a_capture: assert property (p_capture) // R6
        else $error("side select not captured at end of settle");

    property p_rate_follow;
        $changed(pin_sync2_r[`PSM_PIN_RATE_BIT]) |=>
            rate_100_out == $past(pin_sync2_r[`PSM_PIN_RATE_BIT]) &&
            stats_segment_100_out == rate_100_out;
    endproperty
    a_rate_follow: assert property (p_rate_follow) // R2
        else $error("rate or segment not following rate input");

    property p_phy_drive;
        config_valid_out && phy_side_out |->
            expansion_tx_clock_out.oe && expansion_rx_clock_out.oe;
    endproperty
    a_phy_drive: assert property (p_phy_drive) // R4
        else $error("PHY side not driving expansion clocks");

    property p_mac_release;
        !phy_side_out || !config_valid_out |->
            !expansion_tx_clock_out.oe && !expansion_rx_clock_out.oe;
    endproperty
    a_mac_release: assert property (p_mac_release) // R5
        else $error("MAC side still drives expansion clocks");

    property p_slow_clock;
        $changed(div_r) |=> (!$changed(div_r))[*4] ##1 $changed(div_r);
    endproperty
    a_slow_clock: assert property (p_slow_clock) // R7
        else $error("slow clock half period is not five cycles");

    // anchored on the first settle cycle so only one attempt runs
    property p_default_tx;
        state_r == PSM_SETTLE && settle_cnt_r == 2'h0 &&
            ovr_en_r == '0 |->
            port_cfg_out[0].force_tx && rate_100_out ##1
            (state_r == PSM_SETTLE) [*2] ##1 state_r == PSM_RUN;
    endproperty
    a_default_tx: assert property (p_default_tx) // R8
        else $error("reset default is not 100BASE-TX");

    c_phy_run: cover property (
        $rose(config_valid_out) && phy_side_out);
    c_mac_run: cover property (
        $rose(config_valid_out) && !phy_side_out);
    c_slow_phy: cover property (
        config_valid_out && phy_side_out && !rate_100_out);
    c_fast_phy: cover property (
        config_valid_out && phy_side_out && rate_100_out);
    c_override: cover property (
        state_r == PSM_RUN && ovr_en_r != '0);

endmodule
